// ---- logic/pcs_defs.svh ----
// Offsets, field positions, reset values and timing counts of the command and status bank.
//******************************************************************************
//******************************************************************************
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// Register indices; the byte address is four times the index.
`define PCS_IDX_CMD      8'h04
`define PCS_IDX_STAT     8'h06
`define PCS_IDX_CAPP     8'h14

// Command field positions and reset value.
`define PCS_CMD_IO       0
`define PCS_CMD_MEM      1
`define PCS_CMD_PERR     6
`define PCS_CMD_RST      16'h0000

// Status reset value and fixed fields.
`define PCS_STAT_RST     16'h0210
`define PCS_STAT_SPEED   2'h1
`define PCS_STAT_CAP     1'h1

// Cycles from a taken request to the lowered waitrequest.
`define PCS_ACK_CYC      1

`endif

// ---- logic/pcs_pkg.sv ----
// Types shared by the command and status bank.
package pcs_pkg;

  // Host bus events that set status bits, one bit each.
  typedef struct packed {
    logic par_det;
    logic serr_sig;
    logic mst_abort;
    logic tgt_rcvd;
    logic tgt_sig;
    logic dpe;
  } pcs_evt_t;

  // Bus slave handshake states.
  typedef enum logic [0:0] {
    PCS_IDLE = 1'b0,
    PCS_ACK  = 1'b1
  } pcs_bus_st_t;

endpackage

// ---- logic/pcs_core_if.sv ----
// Signals passed between the bank top and its decode and status modules.
`timescale 1ns/1ps
interface pcs_core_if;
  logic             cmd_mem;
  logic             cmd_io;
  pcs_pkg::pcs_evt_t evt;
  logic [15:0]      clr_mask;
  logic [15:0]      status;
  logic             mem_cyc;
  logic             io_cyc;
  logic             bar_hit;
  logic             ccb_hit;
  logic             claim;

  modport top  (output cmd_mem, cmd_io, evt, clr_mask, mem_cyc, io_cyc, bar_hit, ccb_hit,
                input  status, claim);
  modport stat (input evt, clr_mask, output status);
  modport dec  (input cmd_mem, cmd_io, mem_cyc, io_cyc, bar_hit, ccb_hit, output claim);
endinterface

// ---- logic/pcs_decode.sv ----
// Target claim decode gated by the space enables.
`timescale 1ns/1ps
module pcs_decode (
  // Core signals
  pcs_core_if.dec cif
);

  //****************************************************************************
  // Claim
  //****************************************************************************
  // A window hit only counts while the matching space enable is set.
  always_comb begin
    cif.claim = (cif.mem_cyc & cif.cmd_mem & (cif.bar_hit | cif.ccb_hit))
              | (cif.io_cyc & cif.cmd_io & cif.bar_hit);
  end

endmodule

// ---- logic/pcs_status.sv ----
// Sticky event bits and fixed fields of the status word.
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_status (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // Core signals
  pcs_core_if.stat  cif
);

  typedef struct packed {
    pcs_pkg::pcs_evt_t ev;
  } pcs_stat_st_t;

  pcs_stat_st_t st_ff;
  pcs_stat_st_t nxt_st;

  //****************************************************************************
  // Event capture
  //****************************************************************************
  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ev.par_det   = cif.evt.par_det   | (st_ff.ev.par_det   & ~cif.clr_mask[15]);
    nxt_st.ev.serr_sig  = cif.evt.serr_sig  | (st_ff.ev.serr_sig  & ~cif.clr_mask[14]);
    nxt_st.ev.mst_abort = cif.evt.mst_abort | (st_ff.ev.mst_abort & ~cif.clr_mask[13]);
    nxt_st.ev.tgt_rcvd  = cif.evt.tgt_rcvd  | (st_ff.ev.tgt_rcvd  & ~cif.clr_mask[12]);
    nxt_st.ev.tgt_sig   = cif.evt.tgt_sig   | (st_ff.ev.tgt_sig   & ~cif.clr_mask[11]);
    // Writing a one here does nothing; only reset clears this flag.
    nxt_st.ev.dpe       = cif.evt.dpe | st_ff.ev.dpe;
    if (!reset_n_i) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_ff <= nxt_st;
  end

  // Fixed fields ignore writes because only the event flags have a clear path.
  assign cif.status = {st_ff.ev.par_det, st_ff.ev.serr_sig, st_ff.ev.mst_abort,
                       st_ff.ev.tgt_rcvd, st_ff.ev.tgt_sig,
                       `PCS_STAT_SPEED,
                       st_ff.ev.dpe,
                       3'h0,
                       `PCS_STAT_CAP,
                       4'h0};

endmodule

// ---- logic/pcs_top.sv ----
// Host bus command enables and status register bank with an Avalon-MM slave.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_top #(
  parameter int         ADDR_W  = 8,
  parameter logic [7:0] CAP_PTR = 8'h40
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Host bus transaction decode
  input  wire logic              mem_cycle_i,
  input  wire logic              io_cycle_i,
  input  wire logic              window_hit_i,
  input  wire logic              card_ctl_hit_i,
  output logic                   devsel_claim_o,
  // Host bus error events
  input  wire logic              parity_err_i,
  input  wire logic              serr_driven_i,
  input  wire logic              master_abort_i,
  input  wire logic              target_abort_rcvd_i,
  input  wire logic              target_abort_sig_i,
  input  wire logic              perr_observed_i,
  input  wire logic              bus_master_i,
  output logic                   perr_drive_o,
  // Command bits seen by the rest of the function
  output logic                   mem_space_en_o,
  output logic                   io_space_en_o,
  output logic                   parity_resp_en_o
);

  //****************************************************************************
  // Parameter checks
  //****************************************************************************
  // The highest register index must be reachable through the word address.
  if (ADDR_W < 5 || ADDR_W > 30) begin : g_bad_addr_w
    $error("pcs_top: ADDR_W must be between 5 and 30");
  end

  //****************************************************************************
  // State
  //****************************************************************************
  // Command reset word, kept whole so each enable takes its own bit.
  localparam logic [15:0] CMD_RST = `PCS_CMD_RST;

  typedef struct packed {
    pcs_pkg::pcs_bus_st_t bus;
    logic                 wreq;
    logic [31:0]          rdata;
    logic                 cmd_mem;
    logic                 cmd_io;
    logic                 cmd_perr;
    logic                 claim;
    logic                 perr;
  } pcs_top_st_t;

  pcs_top_st_t st_ff;
  pcs_top_st_t nxt_st;

  pcs_core_if cif ();

  //****************************************************************************
  // Helpers
  //****************************************************************************
  // Expands the two low byte enables into a 16-bit bit mask.
  function automatic logic [15:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // Compares the word address with a register index.
  function automatic logic idx_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    idx_is = (a == ADDR_W'(idx));
  endfunction

  //****************************************************************************
  // Bus handshake
  //****************************************************************************
  logic        req;
  logic        take;
  logic        wr_take;
  logic        hit_cmd;
  logic        hit_stat;
  logic        hit_capp;
  logic [15:0] wmask;
  logic [15:0] cmd_word;
  logic [31:0] rd_word;

  assign req      = avs_read_i | avs_write_i;
  // The request completes at the edge where waitrequest is seen low.
  assign take     = req && (st_ff.bus == pcs_pkg::PCS_ACK);
  assign wr_take  = take & avs_write_i;
  assign hit_cmd  = idx_is(avs_address_i, `PCS_IDX_CMD);
  assign hit_stat = idx_is(avs_address_i, `PCS_IDX_STAT);
  assign hit_capp = idx_is(avs_address_i, `PCS_IDX_CAPP);
  assign wmask    = avs_writedata_i[15:0] & be_mask(avs_byteenable_i);

  // Only the three implemented enables hold state; all other command bits read zero.
  always_comb begin
    cmd_word                = `PCS_CMD_RST;
    cmd_word[`PCS_CMD_IO]   = st_ff.cmd_io;
    cmd_word[`PCS_CMD_MEM]  = st_ff.cmd_mem;
    cmd_word[`PCS_CMD_PERR] = st_ff.cmd_perr;
  end

  // Unmapped indices read as zero and ignore writes.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_cmd) begin
      rd_word[15:0] = cmd_word;
    end else if (hit_stat) begin
      rd_word[15:0] = cif.status;
    end else if (hit_capp) begin
      rd_word[7:0] = CAP_PTR;
    end
  end

  //****************************************************************************
  // Status clear path
  //****************************************************************************
  // Ones clear, zeros keep; a read-back write would wipe every pending event except dpe, which has no clear path.
  assign cif.clr_mask = (wr_take && hit_stat) ? wmask : 16'h0000;

  //****************************************************************************
  // Error events
  //****************************************************************************
  logic perr_now;

  // Detection is flagged even when the response enable is off; driving is not.
  assign perr_now            = parity_err_i & st_ff.cmd_perr;
  // Every source here is a host side signal; card side activity has no path in.
  assign cif.evt.par_det     = parity_err_i;
  assign cif.evt.serr_sig    = serr_driven_i;
  assign cif.evt.mst_abort   = master_abort_i & bus_master_i;
  assign cif.evt.tgt_rcvd    = target_abort_rcvd_i & bus_master_i;
  assign cif.evt.tgt_sig     = target_abort_sig_i & ~bus_master_i;
  assign cif.evt.dpe         = (perr_now | perr_observed_i) & bus_master_i
                             & st_ff.cmd_perr;

  //****************************************************************************
  // Claim decode
  //****************************************************************************
  assign cif.cmd_mem = st_ff.cmd_mem;
  assign cif.cmd_io  = st_ff.cmd_io;
  assign cif.mem_cyc = mem_cycle_i;
  assign cif.io_cyc  = io_cycle_i;
  assign cif.bar_hit = window_hit_i;
  assign cif.ccb_hit = card_ctl_hit_i;

  pcs_decode u_decode (
    .cif (cif.dec)
  );

  pcs_status u_status (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .cif       (cif.stat)
  );

  //****************************************************************************
  // Next state
  //****************************************************************************
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.claim = cif.claim;
    nxt_st.perr  = perr_now;
    case (st_ff.bus)
      pcs_pkg::PCS_IDLE: begin
        // Read data is latched together with the lowered waitrequest.
        if (req) begin
          nxt_st.bus   = pcs_pkg::PCS_ACK;
          nxt_st.rdata = rd_word;
        end
      end
      pcs_pkg::PCS_ACK: begin
        nxt_st.bus = pcs_pkg::PCS_IDLE;
        if (wr_take && hit_cmd && avs_byteenable_i[0]) begin
          nxt_st.cmd_io   = avs_writedata_i[`PCS_CMD_IO];
          nxt_st.cmd_mem  = avs_writedata_i[`PCS_CMD_MEM];
          nxt_st.cmd_perr = avs_writedata_i[`PCS_CMD_PERR];
        end
      end
      default: begin
        nxt_st.bus = pcs_pkg::PCS_IDLE;
      end
    endcase
    if (!reset_n_i) begin
      nxt_st          = '0;
      nxt_st.bus      = pcs_pkg::PCS_IDLE;
      nxt_st.cmd_io   = CMD_RST[`PCS_CMD_IO];
      nxt_st.cmd_mem  = CMD_RST[`PCS_CMD_MEM];
      nxt_st.cmd_perr = CMD_RST[`PCS_CMD_PERR];
    end
    // Waitrequest is its own flop so the pin carries no decode after the register.
    nxt_st.wreq = (nxt_st.bus != pcs_pkg::PCS_ACK);
  end

  always_ff @(posedge sys_clk_i) begin
    st_ff <= nxt_st;
  end

  //****************************************************************************
  // Outputs
  //****************************************************************************
  // Waitrequest stays high except for the single completing cycle.
  assign avs_waitrequest_o = st_ff.wreq;
  assign avs_readdata_o    = st_ff.rdata;
  assign devsel_claim_o    = st_ff.claim;
  assign perr_drive_o      = st_ff.perr;
  assign mem_space_en_o    = st_ff.cmd_mem;
  assign io_space_en_o     = st_ff.cmd_io;
  assign parity_resp_en_o  = st_ff.cmd_perr;

endmodule

// ---- verif/pcs_host_agent.sv ----
// Host bus agent driving cycle decode levels and error event pulses.
`timescale 1ns/1ps
module pcs_host_agent (
  // Clock and control
  input  wire logic        sys_clk_i,
  input  wire logic        en_i,
  input  wire logic        master_i,
  // Host bus levels and pulses
  output logic      [10:0] bus_o
);
  int          seed = 11;
  logic [31:0] r;
  initial bus_o = 11'h0;
  // Events are sparse so that each read sees set and clear flags mixed.
  always @(posedge sys_clk_i) begin
    r = $random(seed);
    if (en_i) begin
      bus_o <= {r[30:25] & r[24:19] & r[18:13], master_i, r[3:0]};
    end else begin
      bus_o <= 11'h0;
    end
  end
endmodule

// ---- verif/pcs_top_chk.sv ----
// Port checks of the command and status bank.
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_top_chk #(
  parameter int         ADDR_W  = 8,
  parameter logic [7:0] CAP_PTR = 8'h40
) (
  // Clock and reset
  input wire logic              sys_clk_i,
  input wire logic              reset_n_i,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  // Host bus
  input wire logic              mem_cycle_i,
  input wire logic              io_cycle_i,
  input wire logic              window_hit_i,
  input wire logic              card_ctl_hit_i,
  input wire logic              devsel_claim_o,
  input wire logic              parity_err_i,
  input wire logic              perr_drive_o,
  input wire logic              mem_space_en_o,
  input wire logic              io_space_en_o,
  input wire logic              parity_resp_en_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence rd_done(a); avs_read_i && !avs_waitrequest_o && avs_address_i == a; endsequence
  sequence ack_one; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  claim_eq_a: assert property (
    devsel_claim_o == $past(mem_cycle_i & mem_space_en_o & (window_hit_i | card_ctl_hit_i)
    | io_cycle_i & io_space_en_o & window_hit_i)) else $error("claim mismatch");
  mem_off_a: assert property (
    mem_cycle_i && !io_cycle_i && !mem_space_en_o |=> !devsel_claim_o) else $error("mem claim");
  io_off_a: assert property (
    io_cycle_i && !mem_cycle_i && !io_space_en_o |=> !devsel_claim_o) else $error("io claim");
  perr_drv_a: assert property (
    perr_drive_o == $past(parity_err_i && parity_resp_en_o)) else $error("perr drive");
  req_ans_a: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> ack_one) else $error("no answer");
  speed_a: assert property (
    rd_done(`PCS_IDX_STAT) |-> avs_readdata_o[10:9] == `PCS_STAT_SPEED) else $error("speed");
  low_bits_a: assert property (
    rd_done(`PCS_IDX_STAT) |-> avs_readdata_o[7:0] == 8'h10) else $error("low status bits");
  cap_ptr_a: assert property (
    rd_done(`PCS_IDX_CAPP) |-> avs_readdata_o == {24'h0, CAP_PTR}) else $error("pointer");
endmodule

bind pcs_top pcs_top_chk #(.ADDR_W(ADDR_W), .CAP_PTR(CAP_PTR)) i_pcs_top_chk (
  .sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .mem_cycle_i, .io_cycle_i, .window_hit_i, .card_ctl_hit_i,
  .devsel_claim_o, .parity_err_i, .perr_drive_o, .mem_space_en_o, .io_space_en_o,
  .parity_resp_en_o);

// ---- verif/test_pcs_command_status_bits.sv ----
// Bench of the command and status bank against a reference model.
`timescale 1ns/1ps
`include "pcs_defs.svh"
module test_pcs_command_status_bits;
  localparam logic [7:0] CAP = 8'h5c;
  logic        sys_clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, en, master;
  logic        devsel_claim_o, perr_drive_o, mem_space_en_o, io_space_en_o, parity_resp_en_o;
  logic        ex_cl, ex_pd;
  logic [3:0]  avs_byteenable_i;
  logic [6:0]  ex_cmd;
  logic [7:0]  avs_address_i;
  logic [10:0] b;
  logic [15:0] ex_st;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  int          miscompares, n_checks, cyc, seed = 11;

  pcs_top #(.ADDR_W(8), .CAP_PTR(CAP)) i_pcs_top (
    .sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .mem_cycle_i(b[0]),
    .io_cycle_i(b[1]), .window_hit_i(b[2]), .card_ctl_hit_i(b[3]), .devsel_claim_o,
    .parity_err_i(b[5]), .serr_driven_i(b[6]), .master_abort_i(b[7]),
    .target_abort_rcvd_i(b[8]), .target_abort_sig_i(b[9]), .perr_observed_i(b[10]),
    .bus_master_i(b[4]), .perr_drive_o, .mem_space_en_o, .io_space_en_o, .parity_resp_en_o);
  pcs_host_agent i_pcs_host_agent (.sys_clk_i, .en_i(en), .master_i(master), .bus_o(b));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // The run needs about 2800 cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      `PCS_IDX_STAT: return {16'h0, ex_st};
      `PCS_IDX_CMD:  return {25'h0, ex_cmd};
      `PCS_IDX_CAPP: return {24'h0, CAP};
      default:       return 32'h0;
    endcase
  endfunction
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    avs_address_i    <= a;
    avs_writedata_i  <= d;
    avs_byteenable_i <= be;
    avs_read_i       <= !wr;
    avs_write_i      <= wr;
    @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
    if (!wr) chk(avs_readdata_o, exp_rd(a));
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  //******************
  // Reference model
  //******************
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ex_st  = `PCS_STAT_RST;
      ex_cmd = 7'h0;
      ex_cl  = 1'b0;
      ex_pd  = 1'b0;
    end else begin
      chk(32'(devsel_claim_o), 32'(ex_cl));
      chk(32'(perr_drive_o), 32'(ex_pd));
      chk(32'({parity_resp_en_o, mem_space_en_o, io_space_en_o}),
          32'({ex_cmd[6], ex_cmd[1:0]}));
      ex_cl = (b[0] & ex_cmd[1] & (b[2] | b[3])) | (b[1] & ex_cmd[0] & b[2]);
      ex_pd = b[5] & ex_cmd[6];
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == `PCS_IDX_STAT)
        ex_st[15:11] = ex_st[15:11] & ~(avs_writedata_i[15:11] & {5{avs_byteenable_i[1]}});
      // Set wins over a clear in the same cycle, so events are merged last.
      ex_st = ex_st | {b[5], b[6], b[7] & b[4], b[8] & b[4], b[9] & !b[4], 2'h0,
                       (b[10] | b[5]) & b[4] & ex_cmd[6], 8'h0};
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == `PCS_IDX_CMD
          && avs_byteenable_i[0])
        ex_cmd = avs_writedata_i[6:0] & 7'h43;
    end
  end

  initial begin
    {reset_n_i, avs_read_i, avs_write_i, en, master} = 5'h0;
    avs_address_i    = 8'h0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'h0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    bus(1'b0, `PCS_IDX_STAT, 32'h0, 4'hf);
    bus(1'b0, `PCS_IDX_CMD, 32'h0, 4'hf);
    bus(1'b0, `PCS_IDX_CAPP, 32'h0, 4'hf);
    bus(1'b1, 8'h3f, 32'hffffffff, 4'hf);
    bus(1'b0, 8'h3f, 32'h0, 4'hf);
    bus(1'b1, `PCS_IDX_STAT, 32'hffffffff, 4'hf);
    bus(1'b0, `PCS_IDX_STAT, 32'h0, 4'hf);
    for (int m = 0; m < 16; m++) begin
      master <= m[3];
      bus(1'b1, `PCS_IDX_CMD, ($random(seed) & 32'hffffffbc) | {m[2], 4'h0, m[1:0]}, 4'h1);
      en <= 1'b1;
      repeat (150) @(posedge sys_clk_i);
      en <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      bus(1'b0, `PCS_IDX_CMD, 32'h0, 4'hf);
      bus(1'b0, `PCS_IDX_STAT, 32'h0, 4'hf);
      bus(1'b1, `PCS_IDX_STAT, $random(seed), 4'($random(seed)));
      bus(1'b0, `PCS_IDX_STAT, 32'h0, 4'hf);
    end
    en <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    en        <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    bus(1'b0, `PCS_IDX_STAT, 32'h0, 4'hf);
    bus(1'b0, `PCS_IDX_CMD, 32'h0, 4'hf);
    summarize();
  end
endmodule
